//--- core/adcc_conversion_control.sv
// Function
// - setting go with the converter enabled starts a conversion.
// - hardware clears go when the conversion finishes.
// - software clearing go aborts, keeping already resolved result bits.
// - go cannot be set while the enable bit is zero.
// - sleep clears go and enable, halting and powering down.
// - sleep forces channel select to 11, pin select unchanged.
// - wake leaves pin and channel select at 11, go and enable zero.
// - sleep leaves partial data only if a bit was already resolved.
// - previous result stays readable during the sampling phase.
// - first shift period end clears result and shifts marker one in at the top.
// - each bit shifts the marker right and stores the resolved bit behind.
// - conversion completes after nine marker shifts, then go clears.
// - marker position after abort shows how many bits were resolved.
// - sequencing runs on the system clock only, nothing proceeds asleep.
// - upper pin select bit makes second pin analog, lower the first.
// - channel 00 first pin, 01 second pin, others internal reference.
// - enable one operates the converter, zero shuts it off.
// - any reset sets both pin analog select bits to one.
// - a full conversion takes thirteen bit conversion periods.
`timescale 1ns/1ns
module adcc_conversion_control
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic [1:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdData,
   input wire logic sleepEnter,
   input wire logic wakeEvent,
   input wire logic compareHigh,
   output logic [1:0] pin_analog_select,
   output logic [1:0] channel_select,
   output logic channelFirstPin,
   output logic channelSecondPin,
   output logic channelReference,
   output logic converterPowered,
   output logic samplingActive,
   output logic [7:0] trialCode,
   output logic conversionBusy,
   output logic asleep
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed
   {
      adcc_pkg::adcc_phase_e phase;
      logic [1:0] divCount;
      logic [3:0] stepCount;
      logic goFlag;
      logic converter_enable;
      logic [1:0] pinSel;
      logic [1:0] chanSel;
      logic [7:0] conversion_result;
      logic sleeping;
      logic [7:0] rdData;
   } adcc_state_s;

   adcc_state_s cur;
   adcc_state_s next_cur;

   // ----------------------------------------------------------------
   // helper signals
   // ----------------------------------------------------------------
   logic bitTick;
   logic ctrlWrite;
   logic [7:0] controlView;
   logic [7:0] markerBit;
   logic [7:0] resolved;
   logic startReq;
   logic abortReq;
   logic restartReq;
   logic shiftDone;
   logic sleepNow;
   logic wakeNow;

   // ----------------------------------------------------------------
   // control register view
   // ----------------------------------------------------------------
   always_comb
   begin
      controlView = 8'h00;
      controlView[adcc_pkg::BIT_PIN1] = cur.pinSel[1];
      controlView[adcc_pkg::BIT_PIN0] = cur.pinSel[0];
      controlView[adcc_pkg::BIT_CHAN_HI] = cur.chanSel[1];
      controlView[adcc_pkg::BIT_CHAN_LO] = cur.chanSel[0];
      controlView[adcc_pkg::BIT_GO] = cur.goFlag;
      controlView[adcc_pkg::BIT_ENABLE] = cur.converter_enable;
   end

   // ----------------------------------------------------------------
   // bit resolver
   // ----------------------------------------------------------------
   // the marker is the lowest set bit of the result; bits below it are zero
   for (genvar b = 0; b < 8; b++)
   begin : g_bit
      logic belowClear;
      logic markerAbove;

      // no set bit below this one
      if (b == 0)
      begin : g_bottom
         assign belowClear = 1'b1;
      end
      else
      begin : g_upper
         assign belowClear = !(|cur.conversion_result[b - 1:0]);
      end

      // marker one place up
      if (b == 7)
      begin : g_top
         assign markerAbove = 1'b0;
      end
      else
      begin : g_lower
         assign markerAbove = markerBit[b + 1];
      end

      assign markerBit[b] = cur.conversion_result[b] && belowClear;

      // bit under the marker takes the comparator, marker moves one place down
      assign resolved[b] = markerBit[b] ? compareHigh : (markerAbove || cur.conversion_result[b]);
   end

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   // only the control address takes writes, none while asleep
   assign ctrlWrite = regWrite && (regAddr == adcc_pkg::ADDR_CONTROL) && !cur.sleeping;

   // go is only accepted with the converter enabled
   assign startReq = ctrlWrite && regWrData[adcc_pkg::BIT_GO] && regWrData[adcc_pkg::BIT_ENABLE]
                     && cur.converter_enable && !cur.goFlag;

   // go or enable written low stops the conversion
   assign abortReq = ctrlWrite && (!regWrData[adcc_pkg::BIT_GO] || !regWrData[adcc_pkg::BIT_ENABLE]);

   // go written high as hardware clears it: the set wins
   assign restartReq = ctrlWrite && regWrData[adcc_pkg::BIT_GO] && regWrData[adcc_pkg::BIT_ENABLE] && shiftDone;

   // ----------------------------------------------------------------
   // sequencing events
   // ----------------------------------------------------------------
   // one bit period is a fixed division of the system clock
   assign bitTick = (cur.divCount == adcc_pkg::DIV_LAST);

   // ninth marker shift ends the conversion
   assign shiftDone = (cur.phase == adcc_pkg::ADCC_SHIFT) && bitTick && (cur.stepCount == adcc_pkg::SHIFT_LAST);

   // sleep only enters from the awake state, wake only acts asleep
   assign sleepNow = sleepEnter && !cur.sleeping;
   assign wakeNow = wakeEvent && cur.sleeping;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      next_cur = cur;
      next_cur.divCount = cur.divCount + 2'h1;

      // -------------------------------------------------------------
      // sequencer
      // -------------------------------------------------------------
      unique case (cur.phase)
         adcc_pkg::ADCC_IDLE:
         begin
            next_cur.divCount = 2'h0;
         end
         adcc_pkg::ADCC_SAMPLE:
         begin
            if (bitTick)
            begin
               next_cur.stepCount = cur.stepCount + 4'h1;
               if (cur.stepCount == adcc_pkg::SAMPLE_LAST)
               begin
                  next_cur.phase = adcc_pkg::ADCC_SHIFT;
                  next_cur.stepCount = 4'h0;
               end
            end
         end
         adcc_pkg::ADCC_SHIFT:
         begin
            if (bitTick)
            begin
               next_cur.stepCount = cur.stepCount + 4'h1;
               if (cur.stepCount == 4'h0)
               begin
                  // clear and bring the marker in at the top
                  next_cur.conversion_result = adcc_pkg::MARKER_LOAD;
               end
               else
               begin
                  // resolve the weight under the marker
                  next_cur.conversion_result = resolved;
               end
               if (shiftDone)
               begin
                  // ninth shift pushes the marker out, done
                  // thirteen periods from start to here
                  next_cur.goFlag = 1'b0;
                  next_cur.phase = adcc_pkg::ADCC_IDLE;
                  next_cur.stepCount = 4'h0;
               end
            end
         end
         default:
         begin
            next_cur.phase = adcc_pkg::ADCC_IDLE;
         end
      endcase

      // -------------------------------------------------------------
      // software access to the control register
      // -------------------------------------------------------------
      if (ctrlWrite)
      begin
         next_cur.pinSel = {regWrData[adcc_pkg::BIT_PIN1], regWrData[adcc_pkg::BIT_PIN0]};
         next_cur.chanSel = {regWrData[adcc_pkg::BIT_CHAN_HI], regWrData[adcc_pkg::BIT_CHAN_LO]};
         next_cur.converter_enable = regWrData[adcc_pkg::BIT_ENABLE];
         if (startReq)
         begin
            next_cur.goFlag = 1'b1;
            next_cur.phase = adcc_pkg::ADCC_SAMPLE;
            next_cur.divCount = 2'h0;
            next_cur.stepCount = 4'h0;
         end
         else if (abortReq)
         begin
            // enable cleared also stops the converter
            next_cur.goFlag = 1'b0;
            next_cur.phase = adcc_pkg::ADCC_IDLE;
            next_cur.conversion_result = cur.conversion_result;
            next_cur.stepCount = 4'h0;
         end
         else if (restartReq)
         begin
            // software go=1 meets hardware done: the set wins, restart
            next_cur.goFlag = 1'b1;
            next_cur.phase = adcc_pkg::ADCC_SAMPLE;
            next_cur.divCount = 2'h0;
            next_cur.stepCount = 4'h0;
         end
      end

      // -------------------------------------------------------------
      // sleep and wake take priority over everything else
      // -------------------------------------------------------------
      if (sleepNow)
      begin
         // only bits resolved before this edge survive
         next_cur.goFlag = 1'b0;
         next_cur.converter_enable = 1'b0;
         next_cur.phase = adcc_pkg::ADCC_IDLE;
         next_cur.stepCount = 4'h0;
         next_cur.conversion_result = cur.conversion_result;
         next_cur.chanSel = adcc_pkg::CHAN_SEL_DEFAULT;
         next_cur.pinSel = cur.pinSel;
         next_cur.sleeping = 1'b1;
      end
      else if (cur.sleeping)
      begin
         next_cur.phase = adcc_pkg::ADCC_IDLE;
         next_cur.divCount = 2'h0;
         if (wakeNow)
         begin
            next_cur.pinSel = adcc_pkg::PIN_SEL_DEFAULT;
            next_cur.chanSel = adcc_pkg::CHAN_SEL_DEFAULT;
            next_cur.goFlag = 1'b0;
            next_cur.converter_enable = 1'b0;
            next_cur.sleeping = 1'b0;
         end
      end

      // -------------------------------------------------------------
      // read data, standing only in the cycle after the strobe
      // -------------------------------------------------------------
      if (regRead)
      begin
         unique case (regAddr)
            adcc_pkg::ADDR_CONTROL:
            begin
               next_cur.rdData = controlView;
            end
            adcc_pkg::ADDR_RESULT:
            begin
               next_cur.rdData = cur.conversion_result;
            end
            default:
            begin
               next_cur.rdData = 8'h00;
            end
         endcase
      end
      else
      begin
         next_cur.rdData = 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cur.phase <= adcc_pkg::ADCC_IDLE;
         cur.divCount <= 2'h0;
         cur.stepCount <= 4'h0;
         cur.goFlag <= 1'b0;
         cur.converter_enable <= 1'b0;
         cur.pinSel <= adcc_pkg::PIN_SEL_DEFAULT;
         cur.chanSel <= adcc_pkg::CHAN_SEL_DEFAULT;
         cur.conversion_result <= adcc_pkg::RESULT_RESET;
         cur.sleeping <= 1'b0;
         cur.rdData <= 8'h00;
      end
      else
      begin
         // whole state registered in one step
         cur <= next_cur;
      end
   end

   // ----------------------------------------------------------------
   // register bus outputs
   // ----------------------------------------------------------------
   assign regRdData = cur.rdData;

   // ----------------------------------------------------------------
   // pin and channel outputs
   // ----------------------------------------------------------------
   // one bit per pin, analog when set
   assign pin_analog_select = cur.pinSel;
   assign channel_select = cur.chanSel;
   assign channelFirstPin = (cur.chanSel == adcc_pkg::CHAN_FIRST_PIN);
   assign channelSecondPin = (cur.chanSel == adcc_pkg::CHAN_SECOND_PIN);
   assign channelReference = !channelFirstPin && !channelSecondPin;

   // ----------------------------------------------------------------
   // converter status outputs
   // ----------------------------------------------------------------
   // power follows the enable bit
   assign converterPowered = cur.converter_enable;
   // decode of the phase flop, no extra delay
   assign samplingActive = (cur.phase == adcc_pkg::ADCC_SAMPLE);
   assign trialCode = cur.conversion_result;
   assign conversionBusy = cur.goFlag;
   assign asleep = cur.sleeping;

endmodule // adcc_conversion_control

//--- core/adcc_pkg.sv
package adcc_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [1:0] ADDR_CONTROL = 2'h0;
   localparam logic [1:0] ADDR_RESULT = 2'h1;

   // converter_control field positions
   localparam int BIT_ENABLE = 0;
   localparam int BIT_GO = 1;
   localparam int BIT_CHAN_LO = 2;
   localparam int BIT_CHAN_HI = 3;
   localparam int BIT_PIN0 = 6;
   localparam int BIT_PIN1 = 7;

   // ----------------------------------------------------------------
   // reset and sleep values, and the marker load
   // ----------------------------------------------------------------
   localparam logic [1:0] PIN_SEL_DEFAULT = 2'h3;
   localparam logic [1:0] CHAN_SEL_DEFAULT = 2'h3;
   localparam logic [7:0] RESULT_RESET = 8'h00;
   localparam logic [7:0] MARKER_LOAD = 8'h80;

   // channel codes
   localparam logic [1:0] CHAN_FIRST_PIN = 2'h0;
   localparam logic [1:0] CHAN_SECOND_PIN = 2'h1;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PER_BIT_PERIOD = 4;
   localparam int CONV_BIT_PERIODS = 13;
   localparam int SHIFT_COUNT = 9;
   localparam int SAMPLE_PERIODS = CONV_BIT_PERIODS - SHIFT_COUNT;
   localparam logic [1:0] DIV_LAST = 2'(CLK_PER_BIT_PERIOD - 1);
   localparam logic [3:0] SAMPLE_LAST = 4'(SAMPLE_PERIODS - 1);
   localparam logic [3:0] SHIFT_LAST = 4'(SHIFT_COUNT - 1);

   // ----------------------------------------------------------------
   // sequencer phases, gray coded
   // ----------------------------------------------------------------
   typedef enum logic [1:0]
   {
      ADCC_IDLE = 2'b00,
      ADCC_SAMPLE = 2'b01,
      ADCC_SHIFT = 2'b11
   } adcc_phase_e;

endpackage

//--- sim/adcc_conversion_control_assertions.sv
`timescale 1ns/1ns
module adcc_conversion_control_assertions
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic regRead,
   input wire logic [7:0] regRdData,
   input wire logic sleepEnter,
   input wire logic wakeEvent,
   input wire logic [1:0] pin_analog_select,
   input wire logic [1:0] channel_select,
   input wire logic channelReference,
   input wire logic converterPowered,
   input wire logic samplingActive,
   input wire logic [7:0] trialCode,
   input wire logic conversionBusy,
   input wire logic asleep
);
   logic [5:0] busyCnt;
   // ------------------------------
   // busy length counter
   // ------------------------------
   always_ff @(posedge clk_sys or negedge rst_b)
      if (!rst_b) busyCnt <= 6'h00;
      else if (!conversionBusy) busyCnt <= 6'h00;
      else if (samplingActive && busyCnt > 6'h10) busyCnt <= 6'h01;
      else busyCnt <= busyCnt + 6'h01;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   // ------------------------------
   // properties
   // ------------------------------
   property p_start_en;
      $rose(conversionBusy) |-> $past(converterPowered);
   endproperty
   a_start_en: assert property (p_start_en) else $error("start while off");
   property p_run_len;
      conversionBusy && !samplingActive |-> busyCnt <= 6'h33;
   endproperty
   a_run_len: assert property (p_run_len) else $error("conversion too long");
   property p_marker;
      $fell(samplingActive) ##0 conversionBusy [*5] |-> trialCode == 8'h80;
   endproperty
   a_marker: assert property (p_marker) else $error("marker not loaded");
   property p_sample_hold;
      samplingActive |=> $stable(trialCode);
   endproperty
   a_sample_hold: assert property (p_sample_hold) else $error("result moved in sampling");
   property p_idle_hold;
      !conversionBusy |=> $stable(trialCode);
   endproperty
   a_idle_hold: assert property (p_idle_hold) else $error("result moved while idle");
   property p_off_idle;
      !converterPowered |-> !conversionBusy;
   endproperty
   a_off_idle: assert property (p_off_idle) else $error("busy while off");
   property p_sleep;
      sleepEnter && !asleep |=> asleep && !conversionBusy && !converterPowered
         && channel_select == 2'h3 && $stable(pin_analog_select);
   endproperty
   a_sleep: assert property (p_sleep) else $error("bad sleep entry");
   property p_wake;
      wakeEvent && asleep && !sleepEnter |=> !asleep && pin_analog_select == 2'h3
         && channel_select == 2'h3 && !converterPowered && !conversionBusy;
   endproperty
   a_wake: assert property (p_wake) else $error("bad wake state");
   property p_ref_dec;
      channelReference == channel_select[1];
   endproperty
   a_ref_dec: assert property (p_ref_dec) else $error("bad reference decode");
   property p_rd_idle;
      !$past(regRead) |-> regRdData == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
   c_done: cover property ($fell(conversionBusy) && converterPowered);
   c_sleep: cover property (sleepEnter && conversionBusy);
   c_wake: cover property (wakeEvent && asleep);
endmodule // adcc_conversion_control_assertions

bind adcc_conversion_control adcc_conversion_control_assertions u_adcc_conversion_control_assertions
(
   .clk_sys(clk_sys), .rst_b(rst_b), .regRead(regRead), .regRdData(regRdData),
   .sleepEnter(sleepEnter), .wakeEvent(wakeEvent), .pin_analog_select(pin_analog_select),
   .channel_select(channel_select), .channelReference(channelReference),
   .converterPowered(converterPowered), .samplingActive(samplingActive),
   .trialCode(trialCode), .conversionBusy(conversionBusy), .asleep(asleep)
);

//--- sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   logic clk_sys, rst_b, regWrite, regRead, sleepEnter, wakeEvent, compareHigh;
   logic [1:0] regAddr, pin_analog_select, channel_select;
   logic [7:0] regWrData, regRdData, trialCode, vin;
   logic channelFirstPin, channelSecondPin, channelReference;
   logic converterPowered, samplingActive, conversionBusy, asleep;
   int err_count = 0;
   int checked = 0;
   adcc_conversion_control u_adcc_conversion_control
   (
      .clk_sys(clk_sys), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
      .sleepEnter(sleepEnter), .wakeEvent(wakeEvent), .compareHigh(compareHigh),
      .pin_analog_select(pin_analog_select), .channel_select(channel_select),
      .channelFirstPin(channelFirstPin), .channelSecondPin(channelSecondPin),
      .channelReference(channelReference), .converterPowered(converterPowered),
      .samplingActive(samplingActive), .trialCode(trialCode),
      .conversionBusy(conversionBusy), .asleep(asleep)
   );
   // ------------------------------
   // clock and comparator
   // ------------------------------
   initial
   begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) compareHigh <= (vin >= trialCode);
   // ------------------------------
   // tasks
   // ------------------------------
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge clk_sys);
      regWrite <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk_sys);
      regRead <= 1'b0;
      @(negedge clk_sys);
      chk($sformatf("reg%0d", a), regRdData, exp);
   endtask
   task automatic slp(input logic w);
      @(posedge clk_sys);
      if (w) wakeEvent <= 1'b1;
      else sleepEnter <= 1'b1;
      @(posedge clk_sys);
      sleepEnter <= 1'b0;
      wakeEvent <= 1'b0;
   endtask
   task automatic conv(input logic [7:0] v, input logic [7:0] prev);
      int n;
      vin = v;
      wr(2'h0, 8'hC3);
      rd(2'h1, prev);
      chk("sampling", {7'h00, samplingActive}, 8'h01);
      n = 2;
      do
      begin
         @(negedge clk_sys);
         n++;
      end
      while (conversionBusy && n < 100);
      chk("cycles", 8'(n), 8'h34);
      rd(2'h1, v);
      rd(2'h0, 8'hC1);
   endtask
   // ------------------------------
   // tests
   // ------------------------------
   initial
   begin
      logic [1:0] c;
      {regAddr, regWrData, regWrite, regRead, sleepEnter, wakeEvent} = '0;
      vin = 8'h00;
      rst_b = 1'b0;
      repeat (16) @(posedge clk_sys);
      rst_b <= 1'b1;
      rd(2'h0, 8'hCC);
      rd(2'h1, 8'h00);
      rd(2'h2, 8'h00);
      wr(2'h0, 8'hCE);
      rd(2'h0, 8'hCC);
      $display("reset and enable test done");
      for (int i = 0; i < 4; i++)
      begin
         c = 2'(i);
         wr(2'h0, {c, 2'h3, c, 2'h1});
         rd(2'h0, {c, 2'h0, c, 2'h1});
         chk("decode", {pin_analog_select, channel_select, channelReference, channelSecondPin,
            channelFirstPin, converterPowered}, {c, c, c[1], c == 2'h1, c == 2'h0, 1'b1});
      end
      $display("select test done");
      conv(8'hA5, 8'h00);
      conv(8'h5A, 8'hA5);
      wr(2'h1, 8'hFF);
      wr(2'h3, 8'h00);
      rd(2'h1, 8'h5A);
      $display("conversion test done");
      vin = 8'hFF;
      wr(2'h0, 8'hC3);
      repeat (24) @(posedge clk_sys);
      wr(2'h0, 8'hC1);
      rd(2'h1, 8'hC0);
      rd(2'h0, 8'hC1);
      wr(2'h0, 8'hC3);
      wr(2'h0, 8'hC1);
      rd(2'h1, 8'hC0);
      wr(2'h0, 8'hC3);
      repeat (24) @(posedge clk_sys);
      wr(2'h0, 8'hC2);
      rd(2'h1, 8'hC0);
      chk("off busy", {7'h00, conversionBusy}, 8'h00);
      rd(2'h0, 8'hC0);
      $display("abort test done");
      vin = 8'h00;
      wr(2'h0, 8'h41);
      wr(2'h0, 8'h43);
      repeat (24) @(posedge clk_sys);
      slp(1'b0);
      rd(2'h1, 8'h40);
      chk("trial", trialCode, 8'h40);
      rd(2'h0, 8'h4C);
      wr(2'h0, 8'hC3);
      repeat (30) @(posedge clk_sys);
      rd(2'h0, 8'h4C);
      chk("asleep", {7'h00, asleep}, 8'h01);
      slp(1'b1);
      rd(2'h0, 8'hCC);
      wr(2'h0, 8'hC1);
      wr(2'h0, 8'hC3);
      slp(1'b0);
      rd(2'h1, 8'h40);
      chk("powered", {7'h00, converterPowered}, 8'h00);
      slp(1'b1);
      $display("sleep test done");
      give_verdict();
   end
   initial
   begin
      repeat (3000) @(posedge clk_sys);
      err_count++;
      $display("watchdog expired");
      give_verdict();
   end
endmodule // tb_top
